// [wicsc_pkg.sv]
package wicsc_pkg;

  // ==========================================================
  // register map (byte offsets on the plain register port)
  localparam logic [3:0] WAKE_CONTROL_OFFS  = 4'h0;
  localparam logic [3:0] WAKE_TIMING_OFFS   = 4'h1;
  localparam logic [3:0] WAKE_STATUS_OFFS   = 4'h2;
  localparam logic [3:0] IRQ_MASK_OFFS      = 4'h3;
  localparam logic [3:0] LOW_POWER_OFFS     = 4'h4;
  localparam logic [3:0] HS_CTRL_OFFS       = 4'h5;
  localparam logic [3:0] INPUT_LEVEL_OFFS   = 4'h6;
  localparam int         ADDR_W             = 4;
  localparam int         DATA_W             = 8;

  // ==========================================================
  // field layout of the wake control register
  localparam int         SENSE_SEL_LSB      = 6;
  localparam int         SENSE_SEL_MSB      = 7;
  localparam int         NUM_WAKE_IN        = 6;
  localparam logic [7:0] WAKE_CONTROL_RST   = 8'h00;

  // timing register: forced multiplier at 7-4, sense period at 3-0
  localparam int         FORCE_MULT_LSB     = 4;
  localparam int         SENSE_TIME_LSB     = 0;
  localparam logic [7:0] WAKE_TIMING_RST    = 8'h00;

  // wake status bits
  localparam int         STAT_INPUT_BIT     = 0;
  localparam int         STAT_FORCED_BIT    = 1;

  // cyclic sense select codes
  localparam logic [1:0] CS_OFF             = 2'h0;
  localparam logic [1:0] CS_OUT_ONE         = 2'h1;
  localparam logic [1:0] CS_OUT_TWO         = 2'h2;
  localparam logic [1:0] CS_BOTH            = 2'h3;

  // ==========================================================
  // timing: 1 ms base tick and the high side pulse on-time
  localparam int         CLK_MHZ            = 200;
  localparam int         TICK_US            = 1000;
  localparam int         TICK_CYCLES        = TICK_US * CLK_MHZ;
  localparam int         PULSE_NS           = 100;
  localparam int         PULSE_CYCLES       = (PULSE_NS * CLK_MHZ + 999) / 1000;

  typedef struct packed {
    logic [1:0] cyclicSenseSelect;
    logic [5:0] wakeInEnable;
  } wicsc_ctrl_s;

  typedef enum logic [1:0] {
    ST_ACTIVE,
    ST_LOWPWR,
    ST_WOKEN
  } wicsc_state_e;

endpackage

// [wicsc_period_timer.sv]
`timescale 1ns/100ps
// counts 1 ms ticks and pulses at the cyclic sense period and the forced period
module wicsc_period_timer #(
  parameter int TICK_CYCLES = 200000
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // control
  input  wire logic       run,
  input  wire logic [3:0] senseCode,
  input  wire logic [3:0] forceCode,
  // events
  output logic            senseEvent,
  output logic            forceEvent
);
  initial begin
    if (TICK_CYCLES < 2) $error("TICK_CYCLES too small");
  end

  logic [31:0] tickCnt;
  logic        tick;
  logic [9:0]  msCnt;
  logic [10:0] senseCnt;

  // period in ms for each sense code; codes above 4 fall back to the longest
  function automatic logic [9:0] sensePeriod(input logic [3:0] code);
    case (code)
      4'h0:    sensePeriod = 10'd1;
      4'h1:    sensePeriod = 10'd2;
      4'h2:    sensePeriod = 10'd5;
      4'h3:    sensePeriod = 10'd10;
      4'h4:    sensePeriod = 10'd20;
      default: sensePeriod = 10'd50;
    endcase
  endfunction

  // forced multiplier: 0 off, n gives 2^(n-1), 11xx saturates at 1024
  function automatic logic [10:0] forceMult(input logic [3:0] code);
    if (code >= 4'hb) begin
      forceMult = 11'd1024;
    end else if (code == 4'h0) begin
      forceMult = 11'd0;
    end else begin
      forceMult = 11'(11'd1 << (code - 4'h1));
    end
  endfunction

  always_ff @(posedge sys_clk) begin
    if (rst || !run || tickCnt == 32'(TICK_CYCLES - 1)) begin
      tickCnt <= 32'h0;
    end else begin
      tickCnt <= tickCnt + 32'h1;
    end
  end
  assign tick = run && tickCnt == 32'(TICK_CYCLES - 1);

  always_ff @(posedge sys_clk) begin
    senseEvent <= 1'b0;
    if (rst || !run) begin
      msCnt <= 10'h0;
    end else if (tick) begin
      if (msCnt + 10'h1 >= sensePeriod(senseCode)) begin
        msCnt      <= 10'h0;
        senseEvent <= 1'b1;
      end else begin
        msCnt <= msCnt + 10'h1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    forceEvent <= 1'b0;
    if (rst || !run) begin
      senseCnt <= 11'h0;
    end else if (tick && msCnt + 10'h1 >= sensePeriod(senseCode) && forceMult(forceCode) != 11'h0) begin
      if (senseCnt + 11'h1 >= forceMult(forceCode)) begin
        senseCnt   <= 11'h0;
        forceEvent <= 1'b1;
      end else begin
        senseCnt <= senseCnt + 11'h1;
      end
    end
  end
endmodule

// [wicsc_wake_ctrl.sv]
`timescale 1ns/100ps
// ==========================================================
// Function
// - bits 7-6 select cyclic output: off, high side one, two, or both
// - with no enables set, selected output still pulses, no change detected
// - forced periodic wake runs alongside every cyclic sense setting
// - bit 5 enables wake from input five
// - bit 4 enables wake from input four
// - bit 3 enables wake from input three
// - bit 2 enables wake from input two
// - bit 1 enables wake from input one
// - bit 0 enables wake from input zero
// - sense off: any change on an enabled input wakes; set before low power
// - sense on: change seen only at a cyclic sample, against the previous sample or the value taken at low power entry
// - simultaneous forced and input wake reports forced as source
// - in low power, normal high side settings ignored; cyclic sense drives
module wicsc_wake_ctrl
  import wicsc_pkg::*;
#(
  parameter int TICK_CYCLES_P  = wicsc_pkg::TICK_CYCLES,
  parameter int PULSE_CYCLES_P = wicsc_pkg::PULSE_CYCLES
) (
  // clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  // register port
  input  wire logic [wicsc_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [wicsc_pkg::DATA_W-1:0] regWrData,
  input  wire logic                       regWrite,
  input  wire logic                       regRead,
  output logic [wicsc_pkg::DATA_W-1:0]    regRdData,
  // wake inputs
  input  wire logic [wicsc_pkg::NUM_WAKE_IN-1:0] wakeInputs,
  // high side outputs
  output logic                            highSideOutOne,
  output logic                            highSideOutTwo,
  // status
  output logic                            lowPower,
  output logic                            wakeUp,
  output logic                            irq
);
  import wicsc_pkg::*;

  initial begin
    if (PULSE_CYCLES_P < 1 || PULSE_CYCLES_P > 65535) $error("PULSE_CYCLES_P out of range");
  end

  // ==========================================================
  // registers
  wicsc_ctrl_s  wakeControlReg;
  logic [7:0]   wakeTimingReg;
  logic [1:0]   highSideCtrlReg;
  logic [1:0]   wakeStatus;
  logic [1:0]   irqMask;
  wicsc_state_e state;
  logic [5:0]   lastSample;
  logic [5:0]   inputs;
  logic [15:0]  pulseCnt;
  logic         senseEvent;
  logic         forceEvent;
  logic         sampleNow;
  logic         inputChange;
  logic         enterLowPower;
  logic         statusRead;
  logic [1:0]   next_wakeStatus;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] offs);
    hit = a == offs;
  endfunction

  assign inputs        = wakeInputs;
  assign enterLowPower = regWrite && hit(regAddr, LOW_POWER_OFFS) && regWrData[0];
  assign statusRead    = regRead && hit(regAddr, WAKE_STATUS_OFFS);

  // software writes the control register; all bits read back
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wakeControlReg <= wicsc_ctrl_s'(WAKE_CONTROL_RST);
    end else if (regWrite && hit(regAddr, WAKE_CONTROL_OFFS)) begin
      wakeControlReg <= wicsc_ctrl_s'(regWrData);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wakeTimingReg   <= WAKE_TIMING_RST;
      highSideCtrlReg <= 2'h0;
      irqMask         <= 2'h0;
    end else if (regWrite) begin
      if (hit(regAddr, WAKE_TIMING_OFFS)) begin
        wakeTimingReg <= regWrData;
      end
      if (hit(regAddr, HS_CTRL_OFFS)) begin
        highSideCtrlReg <= regWrData[1:0];
      end
      if (hit(regAddr, IRQ_MASK_OFFS)) begin
        irqMask <= regWrData[1:0];
      end
    end
  end

  // ==========================================================
  // timing
  wicsc_period_timer #(
    .TICK_CYCLES (TICK_CYCLES_P)
  ) u_timer (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .run        (state == ST_LOWPWR),
    .senseCode  (wakeTimingReg[SENSE_TIME_LSB +: 4]),
    .forceCode  (wakeTimingReg[FORCE_MULT_LSB +: 4]),
    .senseEvent (senseEvent),
    .forceEvent (forceEvent)
  );

  // ==========================================================
  // high side pulse: the sample is taken at the end of the on-time
  always_ff @(posedge sys_clk) begin
    if (rst || state != ST_LOWPWR) begin
      pulseCnt <= 16'h0;
    end else if (senseEvent && wakeControlReg.cyclicSenseSelect != CS_OFF) begin
      pulseCnt <= 16'(PULSE_CYCLES_P);
    end else if (pulseCnt != 16'h0) begin
      pulseCnt <= pulseCnt - 16'h1;
    end
  end
  assign sampleNow = pulseCnt == 16'h1;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      highSideOutOne <= 1'b0;
      highSideOutTwo <= 1'b0;
    end else if (state == ST_LOWPWR) begin
      // normal control ignored; pulse even with no enables set
      highSideOutOne <= pulseCnt != 16'h0 && (wakeControlReg.cyclicSenseSelect == CS_OUT_ONE ||
                        wakeControlReg.cyclicSenseSelect == CS_BOTH);
      highSideOutTwo <= pulseCnt != 16'h0 && (wakeControlReg.cyclicSenseSelect == CS_OUT_TWO ||
                        wakeControlReg.cyclicSenseSelect == CS_BOTH);
    end else begin
      highSideOutOne <= highSideCtrlReg[0];
      highSideOutTwo <= highSideCtrlReg[1];
    end
  end

  // ==========================================================
  // change detection
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lastSample <= 6'h0;
    end else if (enterLowPower && state == ST_ACTIVE) begin
      lastSample <= inputs;
    end else if (state == ST_LOWPWR) begin
      if (wakeControlReg.cyclicSenseSelect == CS_OFF || sampleNow) begin
        lastSample <= inputs;
      end
    end
  end

  // per-input enable gating: bit n enables input n
  always_comb begin
    inputChange = 1'b0;
    for (int i = 0; i < NUM_WAKE_IN; i++) begin
      if (wakeControlReg.wakeInEnable[i] && inputs[i] != lastSample[i]) begin
        inputChange = 1'b1;
      end
    end
    if (wakeControlReg.cyclicSenseSelect != CS_OFF && !sampleNow) begin
      inputChange = 1'b0;
    end
  end

  // ==========================================================
  // mode and wake source
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= ST_ACTIVE;
    end else begin
      case (state)
        ST_ACTIVE: begin
          if (enterLowPower) begin
            state <= ST_LOWPWR;
          end
        end
        ST_LOWPWR: begin
          if (forceEvent || (state == ST_LOWPWR && inputChange)) begin
            state <= ST_WOKEN;
          end
        end
        ST_WOKEN: begin
          if (statusRead) begin
            state <= ST_ACTIVE;
          end
        end
        default: state <= ST_ACTIVE;
      endcase
    end
  end

  always_comb begin
    next_wakeStatus = statusRead ? 2'h0 : wakeStatus;
    if (state == ST_LOWPWR) begin
      if (forceEvent) begin
        next_wakeStatus[STAT_FORCED_BIT] = 1'b1;
      end else if (inputChange) begin
        next_wakeStatus[STAT_INPUT_BIT] = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wakeStatus <= 2'h0;
      lowPower   <= 1'b0;
      wakeUp     <= 1'b0;
      irq        <= 1'b0;
    end else begin
      wakeStatus <= next_wakeStatus;
      lowPower   <= state == ST_LOWPWR;
      wakeUp     <= state == ST_LOWPWR && (forceEvent || inputChange);
      irq        <= |(next_wakeStatus & irqMask);
    end
  end

  // ==========================================================
  // read data, one cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      regRdData <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        WAKE_CONTROL_OFFS: regRdData <= wakeControlReg;
        WAKE_TIMING_OFFS:  regRdData <= wakeTimingReg;
        WAKE_STATUS_OFFS:  regRdData <= {6'h0, wakeStatus};
        IRQ_MASK_OFFS:     regRdData <= {6'h0, irqMask};
        LOW_POWER_OFFS:    regRdData <= {7'h0, state == ST_LOWPWR};
        HS_CTRL_OFFS:      regRdData <= {6'h0, highSideCtrlReg};
        INPUT_LEVEL_OFFS:  regRdData <= {2'h0, inputs};
        default:           regRdData <= 8'h00;
      endcase
    end else begin
      regRdData <= 8'h00;
    end
  end
endmodule

// [wicsc_wake_ctrl_checker.sv]
`timescale 1ns/100ps
// ==========
// port checker of the wake control block
module wicsc_wake_ctrl_checker
  import wicsc_pkg::*;
(
  // clock and reset
  input logic       sys_clk,
  input logic       rst,
  // register port
  input logic [3:0] regAddr,
  input logic [7:0] regWrData,
  input logic       regWrite,
  input logic       regRead,
  input logic [7:0] regRdData,
  // pins
  input logic [5:0] wakeInputs,
  input logic       highSideOutOne,
  input logic       highSideOutTwo,
  input logic       lowPower,
  input logic       wakeUp,
  input logic       irq
);
  logic [7:0] ctl;
  logic [7:0] tmg;
  logic [7:0] msk;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // shadows of what software wrote
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctl <= WAKE_CONTROL_RST;
      tmg <= WAKE_TIMING_RST;
      msk <= 8'h00;
    end else if (regWrite) begin
      if (regAddr == WAKE_CONTROL_OFFS) ctl <= regWrData;
      if (regAddr == WAKE_TIMING_OFFS) tmg <= regWrData;
      if (regAddr == IRQ_MASK_OFFS) msk <= regWrData;
    end
  end
  rd_idle_a: assert property (!$past(regRead) |-> regRdData == 8'h00)
    else $error("read data not zero");
  ctl_readback_a: assert property ($past(regRead) && $past(regAddr) == WAKE_CONTROL_OFFS |-> regRdData == ctl)
    else $error("control readback wrong");
  unmapped_rd_a: assert property ($past(regRead) && $past(regAddr) > 4'h6 |-> regRdData == 8'h00)
    else $error("unmapped read not zero");
  hs_one_sel_a: assert property (lowPower && $past(lowPower) && !ctl[SENSE_SEL_LSB] |-> !highSideOutOne)
    else $error("high side one on while not selected");
  hs_two_sel_a: assert property (lowPower && $past(lowPower) && !ctl[SENSE_SEL_MSB] |-> !highSideOutTwo)
    else $error("high side two on while not selected");
  input_wake_a: assert property (lowPower && ctl[7:6] == CS_OFF
    && |((wakeInputs ^ $past(wakeInputs)) & ctl[5:0]) |=> wakeUp)
    else $error("enabled input change did not wake");
  quiet_sleep_a: assert property (lowPower && ctl[7:6] == CS_OFF
    && tmg[7:4] == 4'h0 && ((wakeInputs ^ $past(wakeInputs)) & ctl[5:0]) == 6'h00 |=> !wakeUp)
    else $error("wake without enabled change");
  no_enable_a: assert property ($past(regRead) && $past(regAddr) == WAKE_STATUS_OFFS
    && ctl[5:0] == 6'h00 |-> !regRdData[STAT_INPUT_BIT])
    else $error("input wake with no enables");
  irq_set_a: assert property (wakeUp && msk[STAT_INPUT_BIT] && tmg[7:4] == 4'h0 |-> irq)
    else $error("irq missing on wake");
  stat_clear_a: assert property ($past(regRead) && $past(regAddr) == WAKE_STATUS_OFFS && !wakeUp |-> !irq)
    else $error("irq kept after status read");
  cover property (wakeUp && irq);
  cover property (lowPower && highSideOutOne);
  cover property (lowPower && highSideOutTwo);
endmodule
bind wicsc_wake_ctrl wicsc_wake_ctrl_checker u_chk (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
  .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .wakeInputs(wakeInputs),
  .highSideOutOne(highSideOutOne), .highSideOutTwo(highSideOutTwo), .lowPower(lowPower), .wakeUp(wakeUp), .irq(irq));

// [wicsc_mcu_model.sv]
`timescale 1ns/100ps
// ==========
// host software side: register bus master
module wicsc_mcu_model
  import wicsc_pkg::*;
(
  // clock
  input  logic       sys_clk,
  // register port
  output logic [3:0] regAddr,
  output logic [7:0] regWrData,
  output logic       regWrite,
  output logic       regRead,
  input  logic [7:0] regRdData
);
  initial begin
    regAddr = 4'h0;
    regWrData = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
    regWrData <= ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    regAddr <= ~a;
    #1 d = regRdData;
  endtask
  // enables and select must be written before this is called
  task automatic sleep();
    wr(LOW_POWER_OFFS, 8'h01);
  endtask
endmodule

// [tb.sv]
`timescale 1ns/100ps
// ==========
// testbench
module tb;
  import wicsc_pkg::*;
  logic        sys_clk;
  logic        rst;
  logic [3:0]  regAddr;
  logic [7:0]  regWrData;
  logic        regWrite;
  logic        regRead;
  logic [7:0]  regRdData;
  logic [5:0]  wakeInputs;
  logic        highSideOutOne;
  logic        highSideOutTwo;
  logic        lowPower;
  logic        wakeUp;
  logic        irq;
  int          failCount;
  int          nCompared;
  int          cycles;
  int          n;
  logic [31:0] seed;
  logic [7:0]  v;
  logic [7:0]  rdv;
  logic [1:0]  hs;
  localparam int TB_TICK = 20;
  wicsc_wake_ctrl #(.TICK_CYCLES_P(TB_TICK), .PULSE_CYCLES_P(3)) dut (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .wakeInputs(wakeInputs),
    .highSideOutOne(highSideOutOne), .highSideOutTwo(highSideOutTwo), .lowPower(lowPower), .wakeUp(wakeUp),
    .irq(irq));
  wicsc_mcu_model mcu (.sys_clk(sys_clk), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData(regRdData));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  function automatic logic [7:0] expStat(input logic forced);
    return forced ? 8'h02 : 8'h01;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    nCompared++;
    if (got !== exp) begin
      failCount++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finishTest();
    if (failCount == 0 && nCompared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // waits for the wake pulse, noting high side pulses seen in low power
  task automatic waitWake(input int lim);
    n = 0;
    hs = 2'b00;
    while (wakeUp !== 1'b1 && n < lim) begin
      @(posedge sys_clk);
      #1;
      if (lowPower === 1'b1) hs = hs | {highSideOutTwo, highSideOutOne};
      n++;
    end
  endtask
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failCount++;
      finishTest();
    end
  end
  initial begin
    rst = 1'b1;
    wakeInputs = 6'h00;
    failCount = 0;
    nCompared = 0;
    cycles = 0;
    seed = 32'h00017455;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    mcu.rd(WAKE_CONTROL_OFFS, rdv);
    chk(rdv, WAKE_CONTROL_RST);
    mcu.rd(4'hf, rdv);
    chk(rdv, 8'h00);
    for (int i = 0; i < 14; i++) begin
      v = (i < 8) ? 8'h01 << i : rnd();
      @(posedge sys_clk);
      wakeInputs <= v[5:0];
      mcu.wr(WAKE_CONTROL_OFFS, v);
      mcu.rd(WAKE_CONTROL_OFFS, rdv);
      chk(rdv, v);
      chk({6'h00, lowPower, wakeUp}, 8'h00);
    end
    mcu.wr(WAKE_TIMING_OFFS, 8'h00);
    for (int i = 0; i < 6; i++) begin
      v = 8'h01 << i;
      mcu.wr(WAKE_CONTROL_OFFS, v);
      mcu.wr(IRQ_MASK_OFFS, {7'h00, i[0]});
      mcu.sleep();
      wakeInputs <= wakeInputs ^ ~v[5:0];
      waitWake(8);
      chk({7'h00, wakeUp}, 8'h00);
      @(posedge sys_clk);
      wakeInputs <= wakeInputs ^ v[5:0];
      waitWake(8);
      chk({7'h00, wakeUp}, 8'h01);
      chk({7'h00, irq}, {7'h00, i[0]});
      mcu.rd(WAKE_STATUS_OFFS, rdv);
      chk(rdv, expStat(1'b0));
      chk({6'h00, irq, lowPower}, 8'h00);
    end
    mcu.wr(HS_CTRL_OFFS, 8'h03);
    for (int s = 0; s < 4; s++) begin
      mcu.wr(WAKE_CONTROL_OFFS, {s[1:0], 6'h00});
      mcu.wr(WAKE_TIMING_OFFS, 8'h20);
      chk({6'h00, highSideOutTwo, highSideOutOne}, 8'h03);
      mcu.sleep();
      wakeInputs <= ~wakeInputs;
      waitWake(200);
      chk({6'h00, hs}, {6'h00, s[1:0]});
      chk({7'h00, wakeUp}, 8'h01);
      mcu.rd(WAKE_STATUS_OFFS, rdv);
      chk(rdv, expStat(1'b1));
    end
    // forced wake and an enabled input change land on the same edge
    mcu.wr(WAKE_CONTROL_OFFS, 8'h01);
    mcu.wr(WAKE_TIMING_OFFS, 8'h10);
    mcu.sleep();
    repeat (TB_TICK) @(posedge sys_clk);
    wakeInputs <= wakeInputs ^ 6'h01;
    waitWake(8);
    chk({7'h00, wakeUp}, 8'h01);
    mcu.rd(WAKE_STATUS_OFFS, rdv);
    chk(rdv, expStat(1'b1));
    mcu.wr(WAKE_CONTROL_OFFS, 8'h41);
    mcu.wr(WAKE_TIMING_OFFS, 8'h00);
    mcu.sleep();
    wakeInputs <= wakeInputs ^ 6'h01;
    waitWake(100);
    chk({7'h00, wakeUp}, 8'h01);
    chk({7'h00, n > 15}, 8'h01);
    mcu.rd(WAKE_STATUS_OFFS, rdv);
    chk(rdv, expStat(1'b0));
    finishTest();
  end
endmodule
